// ===== verilog/analog_compare_defs.svh
// Purpose: Offsets, field positions and reset values of the comparator event logic.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes: Included by its bare name; holds definitions only.
// Notes on behaviour
// - Routing bit feeds comparator to timer capture zero.
// - Routing active disconnects external timer channel pin.
// - Interrupt on rising, falling or either edge.
// - Option drives comparator result onto output pin.
// - Enabled comparator keeps working in wait mode.
// - Wait mode event with interrupt enable wakes.
// - Enabled comparator stays active in stop3.
// - Stop3 keeps output pin driven as in run.
// - Stop3 event sets flag, wakes when enabled.
// - Reset on stop exit restores all state.
// - Deep stop powers down, wakes at reset state.
// - Debug halt leaves comparator logic running normally.
// - Edge field: 00/10 fall, 01 rise, 11 both.
// - Flag clears only on written one or deep stop.
// - Level status resets zero, reads zero when disabled.
// - Interrupt enable plus set flag raises request.
`ifndef ANALOG_COMPARE_DEFS_SVH
`define ANALOG_COMPARE_DEFS_SVH

`define CMP_CTRL_OFFSET     8'h00
`define CMP_OPTION_OFFSET   8'h04
`define CMP_STATUS_OFFSET   8'h08
`define CMP_MASK_OFFSET     8'h0C

`define CMP_BIT_ENABLE      7
`define CMP_BIT_REF_SEL     6
`define CMP_BIT_FLAG        5
`define CMP_BIT_IRQ_EN      4
`define CMP_BIT_LEVEL       3
`define CMP_BIT_OUT_EN      2
`define CMP_BIT_ROUTE       0
`define CMP_BIT_EVENT       0

`define CMP_CTRL_RESET      8'h00
`define CMP_ROUTE_RESET     1'b0
`define CMP_SYNC_STAGES     2

`endif

// ===== verilog/analog_compare_pkg.sv
// Purpose: Types shared by the comparator event logic.
// Assumes: Constants come from the defs header.
// Notes: Nothing here is imported; users write the package name.
package analog_compare_pkg;

	typedef enum logic [1:0] {
		EDGE_FALL     = 2'h0,
		EDGE_RISE     = 2'h1,
		EDGE_FALL_ALT = 2'h2,
		EDGE_BOTH     = 2'h3
	} edge_mode_type;

	typedef struct packed {
		logic          enable;
		logic          ref_sel;
		logic          irq_en;
		logic          out_en;
		edge_mode_type edge_sel;
	} control_type;

	typedef struct packed {
		logic out;
		logic oe;
	} pin_drive_type;

endpackage

// ===== verilog/level_sync.sv
// Purpose: Brings asynchronous levels into the pclk domain.
// Assumes: Each bit is an independent level.
// Notes: The first stage is read only by the second.
`timescale 1ns/10ps
module level_sync #(
	parameter int WIDTH = 2
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage1;

	// Two flops in series; the pair trades two cycles of delay for metastability margin.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage1   <= '0;
			sync_out <= '0;
		end else begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end

endmodule

// ===== verilog/edge_event_detect.sv
// Purpose: Decides whether a sampled change is a compare event.
// Assumes: Both inputs are already synchronised to pclk.
// Notes: Purely combinational; the caller registers the result.
`timescale 1ns/10ps
module edge_event_detect (
	input  wire logic                               level_now,
	input  wire logic                               level_prev,
	input  analog_compare_pkg::edge_mode_type       edge_sel,
	output logic                                    hit
);

	logic rising;
	logic falling;

	// Edge decode; both falling encodings are treated alike.
	always_comb begin
		rising  = level_now & ~level_prev;
		falling = ~level_now & level_prev;
		unique case (edge_sel)
			analog_compare_pkg::EDGE_RISE: hit = rising;
			analog_compare_pkg::EDGE_BOTH: hit = rising | falling;
			default: hit = falling;
		endcase
	end

endmodule

// ===== verilog/analog_compare_event_logic.sv
// Purpose: Control, flag and routing logic around an analog comparator.
// Assumes: APB slave on pclk; comparator output arrives asynchronously.
// Notes: Wait and stop3 gate only the wake request; debug halt gates no logic here.
`timescale 1ns/10ps
`include "analog_compare_defs.svh"
module analog_compare_event_logic (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        comparator_raw,
	input  wire logic        timer1_channel0_pin_in,
	input  wire logic        timer_ch0_out,
	input  wire logic        timer_ch0_oe,
	input  wire logic        wait_mode,
	input  wire logic        stop3_mode,
	input  wire logic        deep_stop,
	output logic             timer1_channel0_pin_out,
	output logic             timer1_channel0_pin_oe,
	output logic             capture_ch0_in,
	output logic             comparator_out_pin,
	output logic             comparator_out_pin_oe,
	output logic             reference_select,
	output logic             compare_irq,
	output logic             wake_request
);

	analog_compare_pkg::control_type   ctrl;
	analog_compare_pkg::pin_drive_type timer_pin;
	logic                              cmp_to_capture_route;
	logic                              compare_event_flag;
	logic                              comparator_level_status;
	logic                              cmp_prev;
	logic                              armed;
	logic                              hit;
	logic                              event_hit;
	logic [1:0]                        sync_levels;
	logic                              cmp_sync;
	logic                              pin_sync;
	logic                              setup_phase;
	logic                              write_strobe;
	logic                              clear_flag;
	logic                              addr_known;
	logic [7:0]                        ctrl_view;

	// Comparator output and the timer pin are both foreign to pclk.
	level_sync #(
		.WIDTH    (`CMP_SYNC_STAGES)
	) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in ({timer1_channel0_pin_in, comparator_raw}),
		.sync_out (sync_levels)
	);

	assign cmp_sync = sync_levels[0];
	assign pin_sync = sync_levels[1];

	// Edge classification against the last synchronised sample.
	edge_event_detect u_edge (
		.level_now  (cmp_sync),
		.level_prev (cmp_prev),
		.edge_sel   (ctrl.edge_sel),
		.hit        (hit)
	);

	// An event counts only once the enable has been seen for a cycle, so
	// that switching the module on never reports a false edge.
	assign event_hit = hit & ctrl.enable & armed & ~deep_stop;

	// APB decode; writes take effect in the access phase, always ready.
	assign setup_phase  = psel & ~penable;
	assign write_strobe = psel & penable & pwrite & pready;
	assign addr_known   = (paddr == `CMP_CTRL_OFFSET) || (paddr == `CMP_OPTION_OFFSET) ||
	                      (paddr == `CMP_STATUS_OFFSET) || (paddr == `CMP_MASK_OFFSET);
	assign clear_flag   = write_strobe &
	                      (((paddr == `CMP_CTRL_OFFSET) && pwdata[`CMP_BIT_FLAG]) ||
	                       ((paddr == `CMP_STATUS_OFFSET) && pwdata[`CMP_BIT_EVENT]));

	// Control word in its packed read layout.
	always_comb begin
		ctrl_view                  = `CMP_CTRL_RESET;
		ctrl_view[`CMP_BIT_ENABLE]  = ctrl.enable;
		ctrl_view[`CMP_BIT_REF_SEL] = ctrl.ref_sel;
		ctrl_view[`CMP_BIT_FLAG]    = compare_event_flag;
		ctrl_view[`CMP_BIT_IRQ_EN]  = ctrl.irq_en;
		ctrl_view[`CMP_BIT_LEVEL]   = comparator_level_status;
		ctrl_view[`CMP_BIT_OUT_EN]  = ctrl.out_en;
		ctrl_view[1:0]              = ctrl.edge_sel;
	end

	// Control register; deep stop returns it to reset like a power-down would.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= '0;
		end else if (deep_stop) begin
			ctrl <= '0;
		end else if (write_strobe && paddr == `CMP_CTRL_OFFSET) begin
			ctrl.enable   <= pwdata[`CMP_BIT_ENABLE];
			ctrl.ref_sel  <= pwdata[`CMP_BIT_REF_SEL]; // Buffer enable is software's job.
			ctrl.irq_en   <= pwdata[`CMP_BIT_IRQ_EN];
			ctrl.out_en   <= pwdata[`CMP_BIT_OUT_EN];
			ctrl.edge_sel <= analog_compare_pkg::edge_mode_type'(pwdata[1:0]);
		end else if (write_strobe && paddr == `CMP_MASK_OFFSET) begin
			ctrl.irq_en <= pwdata[`CMP_BIT_EVENT];
		end
	end

	// System option routing bit.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmp_to_capture_route <= `CMP_ROUTE_RESET;
		end else if (deep_stop) begin
			cmp_to_capture_route <= `CMP_ROUTE_RESET;
		end else if (write_strobe && paddr == `CMP_OPTION_OFFSET) begin
			cmp_to_capture_route <= pwdata[`CMP_BIT_ROUTE];
		end
	end

	// Sampling state; of the mode inputs only deep_stop stops it, so wait,
	// stop3 and debug halt all keep detecting while enabled.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmp_prev                <= 1'b0;
			armed                   <= 1'b0;
			comparator_level_status <= 1'b0;
		end else begin
			cmp_prev                <= cmp_sync;
			armed                   <= ctrl.enable & ~deep_stop;
			comparator_level_status <= cmp_sync & ctrl.enable & ~deep_stop;
		end
	end

	// Sticky compare flag; a new event beats a simultaneous clear.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			compare_event_flag <= 1'b0;
		end else if (deep_stop) begin
			compare_event_flag <= 1'b0;
		end else if (event_hit) begin
			compare_event_flag <= 1'b1;
		end else if (clear_flag) begin
			compare_event_flag <= 1'b0;
		end
	end

	// Interrupt and wake requests follow the flag one cycle later.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			compare_irq  <= 1'b0;
			wake_request <= 1'b0;
		end else begin
			compare_irq  <= compare_event_flag & ctrl.irq_en & ~deep_stop;
			wake_request <= compare_event_flag & ctrl.irq_en & ~deep_stop &
			                (wait_mode | stop3_mode);
		end
	end

	// Output pin; nothing here depends on run or stop3, so it behaves alike.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			comparator_out_pin    <= 1'b0;
			comparator_out_pin_oe <= 1'b0;
			reference_select      <= 1'b0;
		end else begin
			comparator_out_pin    <= ctrl.out_en & cmp_sync & ctrl.enable;
			comparator_out_pin_oe <= ctrl.out_en & ~deep_stop;
			reference_select      <= ctrl.ref_sel & ~deep_stop;
		end
	end

	// Timer channel zero: capture source and pin ownership.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_pin      <= '0;
			capture_ch0_in <= 1'b0;
		end else begin
			timer_pin.out  <= timer_ch0_out;
			timer_pin.oe   <= timer_ch0_oe & ~cmp_to_capture_route;
			capture_ch0_in <= cmp_to_capture_route ? comparator_level_status : pin_sync;
		end
	end

	assign timer1_channel0_pin_out = timer_pin.out;
	assign timer1_channel0_pin_oe  = timer_pin.oe;

	// APB answer; read data is latched in setup so the access phase is zero-wait.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= 1'b1;
			if (setup_phase) begin
				pslverr <= ~addr_known;
				unique case (paddr)
					`CMP_CTRL_OFFSET:   prdata <= {24'h00_0000, ctrl_view};
					`CMP_OPTION_OFFSET: prdata <= {31'h0000_0000, cmp_to_capture_route};
					`CMP_STATUS_OFFSET: prdata <= {31'h0000_0000, compare_event_flag};
					`CMP_MASK_OFFSET:   prdata <= {31'h0000_0000, ctrl.irq_en};
					default:            prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Checks on the event path, interrupt, pins and routing.
	a_flag_sets: assert property (@(posedge pclk) disable iff (!presetn)
		event_hit |=> compare_event_flag)
		else $error("Compare event did not set the flag.");

	a_flag_zero_keep: assert property (@(posedge pclk) disable iff (!presetn)
		(compare_event_flag && !clear_flag && !deep_stop) |=> compare_event_flag)
		else $error("Flag dropped without a written one.");

	a_flag_clear_one: assert property (@(posedge pclk) disable iff (!presetn)
		(clear_flag && !event_hit && !deep_stop) |=> !compare_event_flag)
		else $error("Written one did not clear the flag.");

	a_level_disabled: assert property (@(posedge pclk) disable iff (!presetn)
		!ctrl.enable |=> !comparator_level_status)
		else $error("Level status nonzero while disabled.");

	a_sync_depth: assert property (@(posedge pclk) disable iff (!presetn)
		(ctrl.enable && $past(ctrl.enable) && !deep_stop) |=>
		comparator_level_status == $past(comparator_raw, 3))
		else $error("Level status not three cycles behind the raw input.");

	a_irq_follow: assert property (@(posedge pclk) disable iff (!presetn)
		(compare_event_flag && ctrl.irq_en && !deep_stop) |=> compare_irq)
		else $error("Interrupt missing while flag and enable are set.");

	a_irq_masked: assert property (@(posedge pclk) disable iff (!presetn)
		!ctrl.irq_en |=> !compare_irq)
		else $error("Interrupt raised while disabled.");

	a_wake_wait: assert property (@(posedge pclk) disable iff (!presetn)
		(compare_irq && (wait_mode || stop3_mode) && $stable(ctrl.irq_en)
		 && compare_event_flag && !deep_stop) |=> wake_request)
		else $error("No wake request for an enabled event in low power.");

	a_rise_only: assert property (@(posedge pclk) disable iff (!presetn)
		(ctrl.edge_sel == analog_compare_pkg::EDGE_RISE && !cmp_sync && cmp_prev
		 && !compare_event_flag && !deep_stop) |=> !compare_event_flag)
		else $error("Falling edge set the flag in rising mode.");

	a_route_pin_off: assert property (@(posedge pclk) disable iff (!presetn)
		cmp_to_capture_route |=> !timer1_channel0_pin_oe)
		else $error("Timer pin driven while routing is active.");

	a_route_capture: assert property (@(posedge pclk) disable iff (!presetn)
		cmp_to_capture_route |=> capture_ch0_in == $past(comparator_level_status))
		else $error("Capture input not fed by the comparator.");

	a_out_pin: assert property (@(posedge pclk) disable iff (!presetn)
		(ctrl.out_en && ctrl.enable && !deep_stop) |=>
		(comparator_out_pin == $past(cmp_sync)) && comparator_out_pin_oe)
		else $error("Output pin does not follow the comparator.");

	a_deep_clear: assert property (@(posedge pclk) disable iff (!presetn)
		deep_stop |=> (!compare_event_flag && !ctrl.enable && !cmp_to_capture_route))
		else $error("Deep stop left comparator state set.");

	// Edge selection, requests, pins and low-power behaviour. The antecedents
	// name every gate of the event path, so an edge a gate blocks is not flagged as a failure.
	a_rise_sets: assert property (@(posedge pclk) disable iff (!presetn)
		(ctrl.edge_sel == analog_compare_pkg::EDGE_RISE && cmp_sync && !cmp_prev
		 && ctrl.enable && armed && !deep_stop) |=> compare_event_flag)
		else $error("Rising edge did not set the flag in rising mode.");

	a_fall_sets: assert property (@(posedge pclk) disable iff (!presetn)
		((ctrl.edge_sel == analog_compare_pkg::EDGE_FALL ||
		  ctrl.edge_sel == analog_compare_pkg::EDGE_FALL_ALT) && !cmp_sync && cmp_prev
		 && ctrl.enable && armed && !deep_stop) |=> compare_event_flag)
		else $error("Falling edge did not set the flag in falling mode.");

	a_fall_ignores: assert property (@(posedge pclk) disable iff (!presetn)
		((ctrl.edge_sel == analog_compare_pkg::EDGE_FALL ||
		  ctrl.edge_sel == analog_compare_pkg::EDGE_FALL_ALT) && cmp_sync && !cmp_prev
		 && !compare_event_flag && !deep_stop) |=> !compare_event_flag)
		else $error("Rising edge set the flag in falling mode.");

	a_both_sets: assert property (@(posedge pclk) disable iff (!presetn)
		(ctrl.edge_sel == analog_compare_pkg::EDGE_BOTH && (cmp_sync != cmp_prev)
		 && ctrl.enable && armed && !deep_stop) |=> compare_event_flag)
		else $error("Edge did not set the flag in either-edge mode.");

	a_irq_needs_flag: assert property (@(posedge pclk) disable iff (!presetn)
		compare_irq |-> $past(compare_event_flag && ctrl.irq_en))
		else $error("Interrupt raised without an enabled flag.");

	a_wake_stop3: assert property (@(posedge pclk) disable iff (!presetn)
		(compare_event_flag && ctrl.irq_en && stop3_mode && !deep_stop) |=> wake_request)
		else $error("No wake request for an enabled event in stop3.");

	a_wake_needs_mode: assert property (@(posedge pclk) disable iff (!presetn)
		wake_request |-> $past(wait_mode || stop3_mode))
		else $error("Wake request raised outside wait and stop3.");

	a_wait_runs: assert property (@(posedge pclk) disable iff (!presetn)
		(wait_mode && ctrl.enable && !deep_stop) |=>
		comparator_level_status == $past(cmp_sync))
		else $error("Comparator stopped sampling in wait mode.");

	a_stop3_runs: assert property (@(posedge pclk) disable iff (!presetn)
		(stop3_mode && ctrl.enable && !deep_stop) |=>
		comparator_level_status == $past(cmp_sync))
		else $error("Comparator stopped sampling in stop3 mode.");

	a_pin_oe_on: assert property (@(posedge pclk) disable iff (!presetn)
		(ctrl.out_en && !deep_stop) |=> comparator_out_pin_oe)
		else $error("Output pin not enabled while the option is set.");

	a_pin_released: assert property (@(posedge pclk) disable iff (!presetn)
		!ctrl.out_en |=> (!comparator_out_pin_oe && !comparator_out_pin))
		else $error("Output pin driven while the option is clear.");

	a_capture_pin: assert property (@(posedge pclk) disable iff (!presetn)
		!cmp_to_capture_route |=> capture_ch0_in == $past(pin_sync))
		else $error("Capture input not fed by the timer pin.");

	a_timer_pass: assert property (@(posedge pclk) disable iff (!presetn)
		!cmp_to_capture_route |=> (timer1_channel0_pin_oe == $past(timer_ch0_oe)) &&
		(timer1_channel0_pin_out == $past(timer_ch0_out)))
		else $error("Timer pin drive not passed through without routing.");

	a_deep_outputs: assert property (@(posedge pclk) disable iff (!presetn)
		deep_stop |=> (!compare_irq && !wake_request && !comparator_out_pin_oe &&
		               !reference_select))
		else $error("Deep stop left an output active.");

	c_event_wait: cover property (@(posedge pclk) disable iff (!presetn)
		event_hit && wait_mode);

	c_event_stop3: cover property (@(posedge pclk) disable iff (!presetn)
		wake_request && stop3_mode);

	c_both_edges: cover property (@(posedge pclk) disable iff (!presetn)
		event_hit && ctrl.edge_sel == analog_compare_pkg::EDGE_BOTH);

	c_set_and_clear: cover property (@(posedge pclk) disable iff (!presetn)
		event_hit && clear_flag);

	c_route_high: cover property (@(posedge pclk) disable iff (!presetn)
		cmp_to_capture_route && capture_ch0_in);

endmodule

// ===== tb/tb_analog_compare_event_logic.sv
// Purpose: Self-checking bench for the comparator event logic over APB.
// Assumes: APB slave with any number of wait states; comparator and pins are plain levels.
// Notes: Waits after each level change cover the two-flop synchroniser.
`timescale 1ns/10ps
`include "analog_compare_defs.svh"
module tb_analog_compare_event_logic;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        raw;
	logic        pin_in;
	logic        t_out;
	logic        t_oe;
	logic        wait_mode;
	logic        stop3_mode;
	logic        deep_stop;
	logic        pin_out;
	logic        pin_oe;
	logic        capture;
	logic        cmp_pin;
	logic        cmp_pin_oe;
	logic        ref_sel;
	logic        compare_irq;
	logic        wake;
	logic [31:0] d;
	logic        err;
	logic [7:0]  mode;
	int          fails;
	int          comparisons;

	analog_compare_event_logic dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .comparator_raw(raw),
		.timer1_channel0_pin_in(pin_in), .timer_ch0_out(t_out),
		.timer_ch0_oe(t_oe), .wait_mode(wait_mode), .stop3_mode(stop3_mode),
		.deep_stop(deep_stop), .timer1_channel0_pin_out(pin_out),
		.timer1_channel0_pin_oe(pin_oe), .capture_ch0_in(capture),
		.comparator_out_pin(cmp_pin), .comparator_out_pin_oe(cmp_pin_oe),
		.reference_select(ref_sel), .compare_irq(compare_irq),
		.wake_request(wake)
	);

	// The bus clock runs at 40 MHz.
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One APB transfer; the request is held until pready is seen high.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] v,
			output logic [31:0] r);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge pclk);
		penable <= 1'b1;
		// No wait-state count is assumed; only the watchdog ends a stuck access.
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// A comparator level change, then enough edges for sync, flag and irq.
	task automatic setraw(input logic v);
		@(posedge pclk);
		raw <= v;
		tick(6);
	endtask

	task automatic wrap_up;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// A hang is cut short well beyond the few hundred cycles the tests use.
	initial begin
		tick(20000);
		fails++;
		wrap_up;
	end

	initial begin
		{presetn, psel, penable, pwrite, raw, pin_in, t_out, t_oe} = 8'h00;
		{wait_mode, stop3_mode, deep_stop} = 3'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		tick(6);
		presetn <= 1'b1;
		tick(1);
		for (int i = 0; i < 4; i++) begin
			xfer(1'b0, 8'(i * 4), 32'h0, d);
			chk("reset value", 32'h0, d);
			chk("mapped error", 32'h0, err);
		end
		xfer(1'b0, 8'h10, 32'h0, d);
		chk("unmapped data", 32'h0, d);
		chk("unmapped error", 32'h1, err);
		// Every edge encoding against a rise and a fall.
		for (mode = 8'h00; mode < 8'h04; mode++) begin
			xfer(1'b1, `CMP_CTRL_OFFSET, {24'h0, 8'h80 | mode}, d);
			tick(2);
			setraw(1'b1);
			xfer(1'b0, `CMP_CTRL_OFFSET, 32'h0, d);
			chk("rise flag", mode == 8'h01 || mode == 8'h03, d[`CMP_BIT_FLAG]);
			xfer(1'b1, `CMP_CTRL_OFFSET, {24'h0, 8'hA0 | mode}, d);
			setraw(1'b0);
			xfer(1'b0, `CMP_CTRL_OFFSET, 32'h0, d);
			chk("fall flag", mode != 8'h01, d[`CMP_BIT_FLAG]);
			xfer(1'b1, `CMP_CTRL_OFFSET, {24'h0, 8'hA0 | mode}, d);
		end
		setraw(1'b1);
		xfer(1'b1, `CMP_CTRL_OFFSET, 32'h83, d);
		xfer(1'b1, `CMP_STATUS_OFFSET, 32'h0, d);
		xfer(1'b0, `CMP_CTRL_OFFSET, 32'h0, d);
		chk("flag kept", 32'h1, d[`CMP_BIT_FLAG]);
		chk("level on", 32'h1, d[`CMP_BIT_LEVEL]);
		xfer(1'b1, `CMP_STATUS_OFFSET, 32'h1, d);
		xfer(1'b0, `CMP_CTRL_OFFSET, 32'h0, d);
		chk("flag cleared", 32'h0, d[`CMP_BIT_FLAG]);
		xfer(1'b1, `CMP_CTRL_OFFSET, 32'h0, d);
		xfer(1'b0, `CMP_CTRL_OFFSET, 32'h0, d);
		chk("level off", 32'h0, d[`CMP_BIT_LEVEL]);
		// Interrupt and wake-up in wait, then in stop3.
		xfer(1'b1, `CMP_CTRL_OFFSET, 32'h93, d);
		// The comparator stays enabled into wait only because it is the wake source.
		wait_mode <= 1'b1;
		tick(2);
		setraw(1'b0);
		chk("irq", 32'h1, compare_irq);
		chk("wake wait", 32'h1, wake);
		xfer(1'b1, `CMP_MASK_OFFSET, 32'h0, d);
		tick(2);
		chk("irq masked", 32'h0, compare_irq);
		xfer(1'b1, `CMP_MASK_OFFSET, 32'h1, d);
		wait_mode <= 1'b0;
		stop3_mode <= 1'b1;
		tick(2);
		chk("wake stop3", 32'h1, wake);
		xfer(1'b1, `CMP_STATUS_OFFSET, 32'h1, d);
		tick(2);
		chk("irq cleared", 32'h0, compare_irq);
		// Output pin while in stop3; the fall also sets the flag there.
		xfer(1'b1, `CMP_CTRL_OFFSET, 32'h84, d);
		setraw(1'b1);
		chk("out pin oe", 32'h1, cmp_pin_oe);
		chk("out pin high", 32'h1, cmp_pin);
		setraw(1'b0);
		chk("out pin low", 32'h0, cmp_pin);
		xfer(1'b0, `CMP_CTRL_OFFSET, 32'h0, d);
		chk("stop3 flag", 32'h1, d[`CMP_BIT_FLAG]);
		xfer(1'b1, `CMP_CTRL_OFFSET, 32'h80, d);
		tick(2);
		chk("out pin off", 32'h0, cmp_pin_oe);
		// Timer channel routing, with the timer trying to drive its pin.
		t_oe <= 1'b1;
		t_out <= 1'b1;
		pin_in <= 1'b1;
		tick(5);
		chk("timer pin oe", 32'h1, pin_oe);
		chk("timer pin out", 32'h1, pin_out);
		chk("capture pin", 32'h1, capture);
		xfer(1'b1, `CMP_OPTION_OFFSET, 32'h1, d);
		tick(2);
		chk("timer pin cut", 32'h0, pin_oe);
		chk("capture cmp low", 32'h0, capture);
		setraw(1'b1);
		chk("capture cmp high", 32'h1, capture);
		// Deep stop power-down, back in run mode, then a reset in mid-run.
		@(posedge pclk);
		deep_stop <= 1'b1;
		stop3_mode <= 1'b0;
		tick(2);
		deep_stop <= 1'b0;
		xfer(1'b0, `CMP_CTRL_OFFSET, 32'h0, d);
		chk("deep ctrl", 32'h0, d);
		xfer(1'b0, `CMP_OPTION_OFFSET, 32'h0, d);
		chk("deep option", 32'h0, d);
		// The reference buffer sits in power control; a driver turns it on first.
		xfer(1'b1, `CMP_CTRL_OFFSET, 32'hD7, d);
		xfer(1'b1, `CMP_OPTION_OFFSET, 32'h1, d);
		tick(2);
		chk("ref select", 32'h1, ref_sel);
		setraw(1'b0);
		chk("irq run", 32'h1, compare_irq);
		chk("no wake run", 32'h0, wake);
		chk("out pin run", 32'h1, cmp_pin_oe);
		presetn <= 1'b0;
		tick(2);
		chk("irq in reset", 32'h0, compare_irq);
		presetn <= 1'b1;
		tick(1);
		xfer(1'b0, `CMP_CTRL_OFFSET, 32'h0, d);
		chk("reset ctrl", 32'h0, d);
		xfer(1'b0, `CMP_OPTION_OFFSET, 32'h0, d);
		chk("reset option", 32'h0, d);
		chk("reset ref", 32'h0, ref_sel);
		chk("reset out oe", 32'h0, cmp_pin_oe);
		wrap_up;
	end
endmodule
